// ==== logic/idc_identify.sv ====
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module idc_identify #(
  parameter int unsigned PAGE_SHIFT = idc_pkg::DEF_PAGE_SHIFT
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [idc_pkg::REG_AW-1:0] reg_addr_in,
  input wire logic [idc_pkg::REG_DW-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [idc_pkg::REG_DW-1:0] reg_rdata_out,
  input wire logic cmd_valid_in,
  input wire logic [31:0] cmd_dword10_in,
  input wire logic [63:0] cmd_second_page_pointer_in,
  output logic cmd_ready_out,
  output logic data_valid_out,
  output logic [7:0] data_byte_out,
  output logic [idc_pkg::IDX_W-1:0] data_offset_out,
  output logic data_last_out,
  output logic cmd_done_out,
  output logic [1:0] cmd_status_out,
  output logic [idc_pkg::CTRL_W-1:0] target_controller_number_out
);
  if (PAGE_SHIFT < 1 || PAGE_SHIFT > 63)
  begin : g_bad_page
    $error("idc_identify: page shift out of range");
  end

  function automatic logic [7:0] pick_byte(input logic [31:0] word, input logic [1:0] k);
    pick_byte = word[{k, 3'h0} +: 8];
  endfunction

  idc_mem_if mem_bus ();

  idc_str_mem #(
    .DEPTH(idc_pkg::STR_BYTES)
  ) idc_str_mem_inst (
    .clk_in(clk_in),
    .port(mem_bus.mem)
  );

  idc_pkg::idc_state_t state_reg;
  idc_pkg::idc_state_t state_next;
  logic [31:0] ident_reg;
  logic [31:0] oui_arb_reg;
  logic [idc_pkg::CAPS_W-1:0] caps_reg;
  logic ns_mgmt_reg;
  logic [1:0] last_status_reg;
  logic warn_reg;
  logic [idc_pkg::SEL_W-1:0] last_sel_reg;
  logic [idc_pkg::IDX_W-1:0] idx_reg;
  logic s1_valid_reg;
  logic s1_mem_reg;
  logic [7:0] s1_byte_reg;
  logic [idc_pkg::IDX_W-1:0] s1_idx_reg;
  logic [idc_pkg::REG_DW-1:0] rdata_reg;
  logic ready_reg;
  logic data_valid_reg;
  logic [7:0] data_byte_reg;
  logic [idc_pkg::IDX_W-1:0] data_offset_reg;
  logic data_last_reg;
  logic done_reg;
  logic [1:0] status_reg;
  logic [idc_pkg::CTRL_W-1:0] ctrl_num_reg;

  logic [idc_pkg::SEL_W-1:0] cmd_sel;
  logic [idc_pkg::CTRL_W-1:0] cmd_ctrl;
  logic cmd_take;
  logic pointer_ok;
  logic sel_uses_ctrl;
  logic [1:0] cmd_verdict;
  logic in_string;
  logic [7:0] fld_byte;
  logic [idc_pkg::IDX_W-1:0] oui_rel;
  logic [7:0] str_off;
  logic str_wr;

  assign cmd_sel = cmd_dword10_in[idc_pkg::SEL_LSB +: idc_pkg::SEL_W];
  assign cmd_ctrl = cmd_dword10_in[idc_pkg::CTRL_LSB +: idc_pkg::CTRL_W];
  assign cmd_take = cmd_valid_in && (state_reg == idc_pkg::IDC_IDLE);
  // A second entry must start on a page; an offset means a list or a bad buffer
  assign pointer_ok = (cmd_second_page_pointer_in[PAGE_SHIFT-1:0] == '0);
  assign sel_uses_ctrl = (cmd_sel == idc_pkg::SEL_CTRL_LIST_NS) || (cmd_sel == idc_pkg::SEL_CTRL_LIST_ALL);

  always_comb
  begin
    if (cmd_sel != idc_pkg::SEL_CONTROLLER)
    begin
      cmd_verdict = idc_pkg::IDC_ST_BAD_SELECTOR;
    end
    else if (!pointer_ok)
    begin
      cmd_verdict = idc_pkg::IDC_ST_BAD_POINTER;
    end
    else
    begin
      cmd_verdict = idc_pkg::IDC_ST_OK;
    end
  end

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      idc_pkg::IDC_IDLE:
      begin
        if (cmd_take)
        begin
          if (cmd_verdict == idc_pkg::IDC_ST_OK)
          begin
            state_next = idc_pkg::IDC_SEND;
          end
          else
          begin
            state_next = idc_pkg::IDC_FINISH;
          end
        end
      end
      idc_pkg::IDC_SEND:
      begin
        if (idx_reg == idc_pkg::BYTE_LAST)
        begin
          state_next = idc_pkg::IDC_DRAIN;
        end
      end
      idc_pkg::IDC_DRAIN:
      begin
        state_next = idc_pkg::IDC_FINISH;
      end
      idc_pkg::IDC_FINISH:
      begin
        state_next = idc_pkg::IDC_IDLE;
      end
      default:
      begin
        state_next = idc_pkg::IDC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_reg <= idc_pkg::IDC_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      idx_reg <= idc_pkg::BYTE_FIRST;
    end
    else if (state_reg == idc_pkg::IDC_SEND)
    begin
      idx_reg <= idx_reg + 7'h01;
    end
    else
    begin
      idx_reg <= idc_pkg::BYTE_FIRST;
    end
  end

  assign in_string = (idx_reg >= idc_pkg::BYTE_STR_FIRST) && (idx_reg <= idc_pkg::BYTE_STR_LAST);
  assign oui_rel = idx_reg - idc_pkg::BYTE_OUI_LO;

  // Serial, model and firmware strings sit back to back in the string store
  assign mem_bus.rd_en = (state_reg == idc_pkg::IDC_SEND) && in_string;
  assign mem_bus.rd_addr = idx_reg - idc_pkg::BYTE_STR_FIRST;

  always_comb
  begin
    fld_byte = 8'h00;
    if (idx_reg <= idc_pkg::BYTE_SUBSYS_HI)
    begin
      // Vendor code in the low half, subsystem code in the high half
      fld_byte = pick_byte(ident_reg, idx_reg[1:0]);
    end
    else if (idx_reg == idc_pkg::BYTE_ARB)
    begin
      fld_byte = oui_arb_reg[idc_pkg::ARB_LSB +: 8];
    end
    else if ((idx_reg >= idc_pkg::BYTE_OUI_LO) && (idx_reg <= idc_pkg::BYTE_OUI_HI))
    begin
      fld_byte = pick_byte({8'h00, oui_arb_reg[idc_pkg::OUI_W-1:0]}, oui_rel[1:0]);
    end
    else if (idx_reg == idc_pkg::BYTE_CAPS)
    begin
      fld_byte = {5'h00, caps_reg} & idc_pkg::CAPS_USED_MASK;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s1_valid_reg <= 1'b0;
      s1_mem_reg <= 1'b0;
      s1_byte_reg <= 8'h00;
      s1_idx_reg <= idc_pkg::BYTE_FIRST;
    end
    else
    begin
      s1_valid_reg <= (state_reg == idc_pkg::IDC_SEND);
      s1_mem_reg <= in_string;
      s1_byte_reg <= fld_byte;
      s1_idx_reg <= idx_reg;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      data_valid_reg <= 1'b0;
      data_byte_reg <= 8'h00;
      data_offset_reg <= idc_pkg::BYTE_FIRST;
      data_last_reg <= 1'b0;
    end
    else
    begin
      data_valid_reg <= s1_valid_reg;
      data_byte_reg <= s1_valid_reg ? (s1_mem_reg ? mem_bus.rd_data : s1_byte_reg) : 8'h00;
      data_offset_reg <= s1_idx_reg;
      data_last_reg <= s1_valid_reg && (s1_idx_reg == idc_pkg::BYTE_LAST);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      status_reg <= idc_pkg::IDC_ST_OK;
    end
    else
    begin
      ready_reg <= (state_next == idc_pkg::IDC_IDLE);
      done_reg <= (state_reg == idc_pkg::IDC_FINISH);
      if (cmd_take)
      begin
        status_reg <= cmd_verdict;
      end
    end
  end

  // Latched per command so list operations downstream see a stable number
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ctrl_num_reg <= '0;
      warn_reg <= 1'b0;
      last_sel_reg <= '0;
    end
    else if (cmd_take)
    begin
      ctrl_num_reg <= ns_mgmt_reg ? cmd_ctrl : '0;
      warn_reg <= !sel_uses_ctrl && (cmd_ctrl != '0);
      last_sel_reg <= cmd_sel;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      last_status_reg <= idc_pkg::IDC_ST_OK;
    end
    else if (state_reg == idc_pkg::IDC_FINISH)
    begin
      last_status_reg <= status_reg;
    end
  end

  // Identity fields are programmed by software; reprogramming mid-transfer tears the copy
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ident_reg <= idc_pkg::RST_IDENT;
      oui_arb_reg <= idc_pkg::RST_OUI_ARB;
      caps_reg <= idc_pkg::RST_CAPS;
      ns_mgmt_reg <= 1'b0;
    end
    else if (reg_wr_in)
    begin
      case (reg_addr_in)
        idc_pkg::REG_IDENT:
        begin
          ident_reg <= reg_wdata_in;
        end
        idc_pkg::REG_OUI_ARB:
        begin
          oui_arb_reg <= reg_wdata_in;
        end
        idc_pkg::REG_CAPS:
        begin
          caps_reg <= reg_wdata_in[idc_pkg::CAPS_W-1:0];
          ns_mgmt_reg <= reg_wdata_in[idc_pkg::NS_MGMT_BIT];
        end
        default:
        begin
          ident_reg <= ident_reg;
        end
      endcase
    end
  end

  assign str_off = reg_addr_in - idc_pkg::STR_BASE;
  assign str_wr = reg_wr_in && (reg_addr_in >= idc_pkg::STR_BASE) && (32'(str_off) < idc_pkg::STR_BYTES);
  assign mem_bus.wr_en = str_wr;
  assign mem_bus.wr_addr = str_off[idc_pkg::STR_AW-1:0];
  assign mem_bus.wr_data = reg_wdata_in[7:0];

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rdata_reg <= '0;
    end
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        idc_pkg::REG_IDENT:
        begin
          rdata_reg <= ident_reg;
        end
        idc_pkg::REG_OUI_ARB:
        begin
          rdata_reg <= oui_arb_reg;
        end
        idc_pkg::REG_CAPS:
        begin
          rdata_reg <= '0;
          rdata_reg[idc_pkg::CAPS_W-1:0] <= caps_reg;
          rdata_reg[idc_pkg::NS_MGMT_BIT] <= ns_mgmt_reg;
        end
        idc_pkg::REG_STATUS:
        begin
          rdata_reg <= '0;
          rdata_reg[idc_pkg::ST_BUSY_BIT] <= (state_reg != idc_pkg::IDC_IDLE);
          rdata_reg[idc_pkg::ST_CODE_LSB +: 2] <= last_status_reg;
          rdata_reg[idc_pkg::ST_WARN_BIT] <= warn_reg;
          rdata_reg[idc_pkg::ST_SEL_LSB +: idc_pkg::SEL_W] <= last_sel_reg;
        end
        default:
        begin
          // String store is write-only; unmapped words read as zero
          rdata_reg <= '0;
        end
      endcase
    end
    else
    begin
      rdata_reg <= '0;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign cmd_ready_out = ready_reg;
  assign data_valid_out = data_valid_reg;
  assign data_byte_out = data_byte_reg;
  assign data_offset_out = data_offset_reg;
  assign data_last_out = data_last_reg;
  assign cmd_done_out = done_reg;
  assign cmd_status_out = status_reg;
  assign target_controller_number_out = ctrl_num_reg;
endmodule // idc_identify
`default_nettype wire

// ==== logic/idc_pkg.sv ====
// Operation
// - Dword 10 bits 31:16 carry the target controller number for operations needing it.
// - With namespace management enabled the controller number is honoured, not dropped.
// - Dword 10 bits 7:0 select which identification structure is returned.
// - Bytes 1:0 return the same vendor code as the configuration identity register.
// - Bytes 3:2 return the same subsystem vendor code as the subsystem register.
// - Bytes 23:4 return the vendor serial number as an ASCII string.
// - Bytes 63:24 return the vendor model number as an ASCII string.
// - Bytes 71:64 return the active firmware revision, same as the log page copy.
// - Byte 72 returns the suggested arbitration burst.
// - Bytes 75:73 return the vendor 24-bit organisation identifier.
// - Byte 76 is the sharing capability byte; bits 7:3 return zero.
// - Capability bit 2 is one for a virtual function, zero for a physical one.
// - Capability bit 1 is one when the subsystem may hold several controllers.
// - Capability bit 0 is one when the subsystem may have several link ports.
// - Selector 01h returns the controller structure of the receiving controller.
`default_nettype none
package idc_pkg;
  localparam int unsigned REG_AW = 8;
  localparam int unsigned REG_DW = 32;
  localparam logic [7:0] REG_IDENT = 8'h00;
  localparam logic [7:0] REG_OUI_ARB = 8'h01;
  localparam logic [7:0] REG_CAPS = 8'h02;
  localparam logic [7:0] REG_STATUS = 8'h03;
  localparam logic [7:0] STR_BASE = 8'h80;
  localparam int unsigned STR_BYTES = 68;
  localparam int unsigned STR_AW = 7;
  localparam int unsigned IDX_W = 7;
  localparam logic [6:0] BYTE_FIRST = 7'h00;
  localparam logic [6:0] BYTE_SUBSYS_HI = 7'h03;
  localparam logic [6:0] BYTE_STR_FIRST = 7'h04;
  localparam logic [6:0] BYTE_STR_LAST = 7'h47;
  localparam logic [6:0] BYTE_ARB = 7'h48;
  localparam logic [6:0] BYTE_OUI_LO = 7'h49;
  localparam logic [6:0] BYTE_OUI_HI = 7'h4B;
  localparam logic [6:0] BYTE_CAPS = 7'h4C;
  localparam logic [6:0] BYTE_LAST = 7'h4C;
  localparam int unsigned SEL_LSB = 0;
  localparam int unsigned SEL_W = 8;
  localparam int unsigned CTRL_LSB = 16;
  localparam int unsigned CTRL_W = 16;
  localparam logic [7:0] SEL_CONTROLLER = 8'h01;
  localparam logic [7:0] SEL_CTRL_LIST_NS = 8'h12;
  localparam logic [7:0] SEL_CTRL_LIST_ALL = 8'h13;
  localparam logic [7:0] CAPS_USED_MASK = 8'h07;
  localparam int unsigned CAPS_W = 3;
  localparam int unsigned NS_MGMT_BIT = 8;
  localparam int unsigned OUI_W = 24;
  localparam int unsigned ARB_LSB = 24;
  localparam int unsigned ST_BUSY_BIT = 0;
  localparam int unsigned ST_CODE_LSB = 4;
  localparam int unsigned ST_WARN_BIT = 8;
  localparam int unsigned ST_SEL_LSB = 16;
  localparam logic [31:0] RST_IDENT = 32'h0000_0000;
  localparam logic [31:0] RST_OUI_ARB = 32'h0000_0000;
  localparam logic [2:0] RST_CAPS = 3'h0;
  localparam int unsigned DEF_PAGE_SHIFT = 12;
  typedef enum logic [1:0] {
    IDC_ST_OK = 2'h0,
    IDC_ST_BAD_SELECTOR = 2'h1,
    IDC_ST_BAD_POINTER = 2'h2
  } idc_status_t;
  typedef enum logic [1:0] {
    IDC_IDLE = 2'h0,
    IDC_SEND = 2'h1,
    IDC_DRAIN = 2'h3,
    IDC_FINISH = 2'h2
  } idc_state_t;
endpackage
`default_nettype wire

// ==== logic/idc_mem_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface idc_mem_if;
  logic wr_en;
  logic [idc_pkg::STR_AW-1:0] wr_addr;
  logic [7:0] wr_data;
  logic rd_en;
  logic [idc_pkg::STR_AW-1:0] rd_addr;
  logic [7:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
endinterface // idc_mem_if
`default_nettype wire

// ==== logic/idc_str_mem.sv ====
`timescale 1ns/10ps
`default_nettype none
module idc_str_mem #(
  parameter int unsigned DEPTH = idc_pkg::STR_BYTES
) (
  input wire logic clk_in,
  idc_mem_if.mem port
);
  if (DEPTH < 1 || DEPTH > (1 << idc_pkg::STR_AW))
  begin : g_bad_depth
    $error("idc_str_mem: depth does not fit the address width");
  end

  logic [7:0] store_reg [DEPTH];
  logic [7:0] rd_data_reg;

  // No reset on the array: strings are loaded by software after reset
  always_ff @(posedge clk_in)
  begin
    if (port.wr_en && (32'(port.wr_addr) < DEPTH))
    begin
      store_reg[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (port.rd_en && (32'(port.rd_addr) < DEPTH))
    begin
      rd_data_reg <= store_reg[port.rd_addr];
    end
    else
    begin
      rd_data_reg <= 8'h00;
    end
  end

  assign port.rd_data = rd_data_reg;
endmodule // idc_str_mem
`default_nettype wire

// ==== logic/idc_identify_note.sv ====
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ==== tb/idc_identify_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module idc_identify_sva #(
  parameter int unsigned PAGE_SHIFT = 12
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic reg_rd_in,
  input wire logic [idc_pkg::REG_DW-1:0] reg_rdata_out,
  input wire logic cmd_valid_in,
  input wire logic [31:0] cmd_dword10_in,
  input wire logic [63:0] cmd_second_page_pointer_in,
  input wire logic cmd_ready_out,
  input wire logic data_valid_out,
  input wire logic [7:0] data_byte_out,
  input wire logic [idc_pkg::IDX_W-1:0] data_offset_out,
  input wire logic data_last_out,
  input wire logic cmd_done_out,
  input wire logic [1:0] cmd_status_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Misaligned pointers are left out: with both faults the bad selector wins over the bad pointer
  sequence ok_take;
    cmd_valid_in && cmd_ready_out && cmd_second_page_pointer_in[PAGE_SHIFT-1:0] == '0
      && cmd_dword10_in[7:0] == idc_pkg::SEL_CONTROLLER;
  endsequence
  sequence sel_take;
    cmd_valid_in && cmd_ready_out && cmd_second_page_pointer_in[PAGE_SHIFT-1:0] == '0
      && cmd_dword10_in[7:0] != idc_pkg::SEL_CONTROLLER;
  endsequence
  sequence data_start;
    !cmd_ready_out ##2 data_valid_out && data_offset_out == 7'h00;
  endsequence
  first_byte_a: assert property (ok_take |=> data_start)
    else $error("first byte not at offset zero");
  last_byte_a: assert property (ok_take |-> ##79 data_last_out && data_offset_out == idc_pkg::BYTE_LAST)
    else $error("last byte misplaced");
  ok_done_a: assert property (ok_take |-> ##80 cmd_done_out && cmd_status_out == idc_pkg::IDC_ST_OK)
    else $error("good command done late or failed");
  busy_hold_a: assert property (ok_take |=> !cmd_ready_out [*8])
    else $error("ready while busy");
  bad_sel_a: assert property (sel_take |=> cmd_status_out == idc_pkg::IDC_ST_BAD_SELECTOR
    ##1 cmd_done_out && !data_valid_out)
    else $error("other selector not refused");
  caps_rsvd_a: assert property (data_valid_out && data_offset_out == idc_pkg::BYTE_CAPS
    |-> data_byte_out[7:3] == 5'h00)
    else $error("reserved capability bits set");
  offset_step_a: assert property (data_valid_out && !data_last_out
    |=> data_valid_out && data_offset_out == $past(data_offset_out) + 7'h01)
    else $error("offsets not ascending");
  idle_byte_a: assert property (!data_valid_out |-> data_byte_out == 8'h00)
    else $error("byte shown while not valid");
  rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule // idc_identify_sva
`default_nettype wire

// ==== tb/idc_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module idc_host_model (
  input wire logic clk_in,
  input wire logic cmd_ready_in,
  input wire logic data_valid_in,
  input wire logic [7:0] data_byte_in,
  input wire logic [6:0] data_offset_in,
  input wire logic cmd_done_in,
  output logic cmd_valid_out,
  output logic [31:0] cmd_dword10_out,
  output logic [63:0] cmd_second_page_pointer_out
);
  logic [7:0] buf_mem [0:76];
  int bytes_seen = 0;
  int dones_seen = 0;
  initial
  begin
    cmd_valid_out = 1'b0;
    cmd_dword10_out = 32'h0000_0000;
    cmd_second_page_pointer_out = 64'h0;
  end
  always @(posedge clk_in)
  begin
    if (data_valid_in)
    begin
      buf_mem[data_offset_in] <= data_byte_in;
      bytes_seen <= bytes_seen + 1;
    end
    if (cmd_done_in)
      dones_seen <= dones_seen + 1;
  end
  // Held while refused; released fields show inverted junk, not stale values
  task automatic issue(input logic [7:0] sel, input logic [15:0] ctrl, input logic [63:0] ptr);
    cmd_valid_out <= 1'b1;
    cmd_dword10_out <= {ctrl, 8'h00, sel};
    cmd_second_page_pointer_out <= ptr;
    for (int n = 0; n < 300; n++)
    begin
      @(posedge clk_in);
      if (cmd_ready_in === 1'b1) break;
    end
    cmd_valid_out <= 1'b0;
    cmd_dword10_out <= ~{ctrl, 8'h00, sel};
    cmd_second_page_pointer_out <= ~ptr;
  endtask
endmodule // idc_host_model
`default_nettype wire

// ==== tb/identify_cmd_controller_data_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module identify_cmd_controller_data_tb_top;
  localparam logic [15:0] VEND = 16'h1A2B; // Arbitrary value
  localparam logic [15:0] SUBV = 16'h3C4D; // Arbitrary value
  localparam logic [23:0] ORG = 24'h5E_6F70; // Arbitrary value
  localparam logic [7:0] ARB = 8'h06;
  localparam logic [63:0] PG = 64'h0000_0001_2345_6000;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out, cmd_dword10_in, rd;
  logic [63:0] cmd_second_page_pointer_in;
  logic cmd_valid_in, cmd_ready_out, data_valid_out, data_last_out, cmd_done_out;
  logic [7:0] data_byte_out, caps_now;
  logic [6:0] data_offset_out;
  logic [1:0] cmd_status_out;
  logic [15:0] target_controller_number_out;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  initial forever #10 clk_in = ~clk_in;
  idc_identify #(.PAGE_SHIFT(12)) idc_identify_inst (.clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .cmd_valid_in, .cmd_dword10_in, .cmd_second_page_pointer_in,
    .cmd_ready_out, .data_valid_out, .data_byte_out, .data_offset_out, .data_last_out, .cmd_done_out,
    .cmd_status_out, .target_controller_number_out);
  idc_host_model idc_host_model_inst (.clk_in, .cmd_ready_in(cmd_ready_out), .data_valid_in(data_valid_out),
    .data_byte_in(data_byte_out), .data_offset_in(data_offset_out), .cmd_done_in(cmd_done_out),
    .cmd_valid_out(cmd_valid_in), .cmd_dword10_out(cmd_dword10_in),
    .cmd_second_page_pointer_out(cmd_second_page_pointer_in));
  task automatic end_sim();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      failures++;
      end_sim();
    end
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Each bus task ends on a clock edge with an idle cycle behind it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    rd = reg_rdata_out;
    @(posedge clk_in);
  endtask
  task automatic wait_done();
    for (int n = 0; n < 200; n++)
    begin
      @(posedge clk_in);
      #1;
      if (cmd_done_out === 1'b1) break;
    end
    check(cmd_done_out, 1'b1);
    @(posedge clk_in);
  endtask
  function automatic logic [7:0] exp_byte(input int k);
    if (k < 2) return VEND[8*k +: 8];
    if (k < 4) return SUBV[8*(k-2) +: 8];
    if (k < 72) return 8'h21 + 8'(k - 4);
    if (k == 72) return ARB;
    if (k < 76) return ORG[8*(k-73) +: 8];
    return caps_now & 8'h07;
  endfunction
  task automatic t_reset();
    logic [7:0] addrs [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h80};
    foreach (addrs[i])
    begin
      rd_reg(addrs[i]);
      check(rd, 32'h0);
    end
  endtask
  task automatic t_program();
    wr(8'h00, {SUBV, VEND});
    wr(8'h01, {ARB, ORG});
    for (int n = 0; n < 68; n++)
      wr(idc_pkg::STR_BASE + 8'(n), {24'h0, 8'h21 + 8'(n)});
  endtask
  // A second command waits refused behind the first and is taken in its done cycle
  task automatic t_good(input logic [31:0] caps_w);
    int b0;
    int d0;
    wr(8'h02, caps_w);
    caps_now = caps_w[7:0];
    b0 = idc_host_model_inst.bytes_seen;
    d0 = idc_host_model_inst.dones_seen;
    idc_host_model_inst.issue(8'h01, 16'h0000, PG);
    // Valid drops for one edge so the host never re-drives it in the same step
    @(posedge clk_in);
    idc_host_model_inst.issue(8'h13, 16'h0000, PG);
    wait_done();
    // Register read first lets the model's last done count settle
    rd_reg(8'h00);
    check(rd, {SUBV, VEND});
    check(idc_host_model_inst.bytes_seen - b0, 77);
    check(idc_host_model_inst.dones_seen - d0, 2);
    for (int k = 0; k < 77; k++)
      check(idc_host_model_inst.buf_mem[k], exp_byte(k));
  endtask
  task automatic t_err(input logic [7:0] sel, input logic [15:0] ctrl, input logic [63:0] ptr,
    input logic [1:0] est, input logic [15:0] etgt, input logic [31:0] estreg);
    int b0;
    b0 = idc_host_model_inst.bytes_seen;
    idc_host_model_inst.issue(sel, ctrl, ptr);
    wait_done();
    check(cmd_status_out, est);
    check(target_controller_number_out, etgt);
    rd_reg(8'h03);
    check(rd, estreg);
    check(idc_host_model_inst.bytes_seen - b0, 0);
  endtask
  initial
  begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_reset();
    t_program();
    t_good(32'h0000_01FD);
    t_good(32'h0000_00FA);
    wr(8'h02, 32'h0000_0100);
    t_err(8'h12, 16'hABCD, PG, 2'h1, 16'hABCD, 32'h0012_0010);
    wr(8'h02, 32'h0000_0000);
    t_err(8'h13, 16'h5A5A, PG, 2'h1, 16'h0000, 32'h0013_0010);
    t_err(8'h00, 16'h0001, PG, 2'h1, 16'h0000, 32'h0000_0110);
    t_err(8'h01, 16'h0000, PG | 64'h800, 2'h2, 16'h0000, 32'h0001_0020);
    end_sim();
  end
endmodule // identify_cmd_controller_data_tb_top
bind idc_identify idc_identify_sva #(.PAGE_SHIFT(PAGE_SHIFT)) idc_identify_sva_inst (.clk_in(clk_in),
  .rst_in(rst_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .cmd_valid_in(cmd_valid_in),
  .cmd_dword10_in(cmd_dword10_in), .cmd_second_page_pointer_in(cmd_second_page_pointer_in),
  .cmd_ready_out(cmd_ready_out), .data_valid_out(data_valid_out), .data_byte_out(data_byte_out),
  .data_offset_out(data_offset_out), .data_last_out(data_last_out), .cmd_done_out(cmd_done_out),
  .cmd_status_out(cmd_status_out));
`default_nettype wire
